// [core/global_register_bank.sv]
// Purpose: Global registers of the access manager, two access ports
// Assumes: Two-wire slave engine and microcontroller give byte strobes
// Notes: Two-wire port has priority; page accesses above 16 bytes pass on
`timescale 1ns/1ps
`default_nettype none
module global_register_bank #(
	parameter logic [6:0] CHIP_IDENT = global_regs_pkg::CHIP_IDENT_DEFAULT,
	parameter int HOLD = global_regs_pkg::RESTART_HOLD_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ser_wr,
	input wire logic ser_rd,
	input wire logic [7:0] ser_addr,
	input wire logic [7:0] ser_wdata,
	output logic [7:0] ser_rdata,
	output logic ser_ack,
	output logic ser_pass,
	output logic [1:0] ser_pass_page,
	output logic [7:0] ser_pass_addr,
	output logic ser_pass_wr,
	output logic [7:0] ser_pass_wdata,
	input wire logic uc_wr,
	input wire logic uc_rd,
	input wire logic [15:0] uc_addr,
	input wire logic [7:0] uc_wdata,
	output logic [7:0] uc_rdata,
	output logic uc_ack,
	input wire logic [3:0] conv_fault_in,
	input wire logic [6:0] reg_fault_in,
	output logic [6:0] regulator_enables,
	output logic regulator_fault_irq,
	output logic converter_fault_irq,
	output logic system_restart
);
	// The restart counter is eight bits, so the pulse length is capped
	if (HOLD < 1 || HOLD > 255) begin : g_bad_hold
		$error("global_register_bank: HOLD out of range");
	end
	// Field widths are tied to the register layout; refuse any drift
	if ($bits(ser_pass_page) != global_regs_pkg::PAGE_W) begin : g_bad_page
		$error("global_register_bank: page width mismatch");
	end
	if ($bits(conv_fault_in) != global_regs_pkg::CONV_FAULT_W) begin : g_bad_cf
		$error("global_register_bank: converter fault width mismatch");
	end
	if ($bits(reg_fault_in) != global_regs_pkg::REG_FAULT_W) begin : g_bad_rf
		$error("global_register_bank: regulator fault width mismatch");
	end
	if ($bits(regulator_enables) != global_regs_pkg::REG_EN_W) begin : g_bad_en
		$error("global_register_bank: enable width mismatch");
	end
	// Busy bit sits on top of the identity field in the read mux
	if (global_regs_pkg::RESTART_BIT != 7) begin : g_bad_rbit
		$error("global_register_bank: restart bit must be bit seven");
	end
	// Offsets are eight bits, so the alias span must fit below 256
	if (!(global_regs_pkg::ALIAS_SPAN inside {[1:255]})) begin : g_bad_span
		$error("global_register_bank: alias span out of range");
	end

	function automatic logic is_global(input logic [7:0] a);
		is_global = (a < 8'(global_regs_pkg::ALIAS_SPAN));
	endfunction : is_global

	// Faults arrive from analog blocks, so they are synchronised first
	logic [3:0] conv_s1_ff;
	logic [3:0] conv_s2_ff;
	logic [6:0] regf_s1_ff;
	logic [6:0] regf_s2_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_s1_ff <= 4'h0;
			conv_s2_ff <= 4'h0;
			regf_s1_ff <= 7'h00;
			regf_s2_ff <= 7'h00;
		end else begin
			conv_s1_ff <= conv_fault_in;
			conv_s2_ff <= conv_s1_ff;
			regf_s1_ff <= reg_fault_in;
			regf_s2_ff <= regf_s1_ff;
		end
	end

	// Arbitration: serial port wins, the microcontroller strobe is refused that cycle
	logic ser_glob;
	logic uc_hit;
	logic uc_go;
	logic wr_en;
	logic [7:0] wr_off;
	logic [7:0] wr_data;
	logic [7:0] uc_off;
	always_comb begin
		ser_glob = is_global(ser_addr);
		uc_off = uc_addr[7:0];
		uc_hit = (uc_addr[15:8] == global_regs_pkg::UC_GLOBAL_BASE[15:8])
			&& is_global(uc_off);
		// A refused uc strobe gets no ack; its source must issue it again
		uc_go = (uc_wr || uc_rd) && !(ser_wr || ser_rd);
		wr_en = 1'b0;
		wr_off = 8'h00;
		wr_data = 8'h00;
		if (ser_wr && ser_glob) begin
			wr_en = 1'b1;
			wr_off = ser_addr;
			wr_data = ser_wdata;
		end else if (uc_go && uc_wr && uc_hit) begin
			wr_en = 1'b1;
			wr_off = uc_off;
			wr_data = uc_wdata;
		end
	end

	// Stored fields; spare bits of bank select, converter fault and enables are kept so that they read back
	logic [1:0] page_ff;
	logic [1:0] nxt_page;
	logic [5:0] page_spare_ff;
	logic [5:0] nxt_page_spare;
	logic [3:0] conv_spare_ff;
	logic [3:0] nxt_conv_spare;
	logic [6:0] en_ff;
	logic [6:0] nxt_en;
	logic en_spare_ff;
	logic nxt_en_spare;
	logic restart_req;
	logic restart_busy;
	always_comb begin
		nxt_page = page_ff;
		nxt_page_spare = page_spare_ff;
		nxt_conv_spare = conv_spare_ff;
		nxt_en = en_ff;
		nxt_en_spare = en_spare_ff;
		restart_req = 1'b0;
		if (wr_en) begin
			case (wr_off)
				global_regs_pkg::OFF_RESTART_IDENT: begin
					// Identity bits ignore writes
					restart_req = wr_data[global_regs_pkg::RESTART_BIT];
				end
				global_regs_pkg::OFF_BANK_SELECT: begin
					nxt_page = wr_data[1:0];
					nxt_page_spare = wr_data[7:2];
				end
				global_regs_pkg::OFF_CONV_FAULT: begin
					nxt_conv_spare = wr_data[7:4];
				end
				global_regs_pkg::OFF_REG_FAULT: begin
					// Fault flags have no storage, so writes fall away
				end
				global_regs_pkg::OFF_REG_ENABLES: begin
					nxt_en = wr_data[6:0];
					nxt_en_spare = wr_data[7];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data muxing shared by both ports
	function automatic logic [7:0] rd_mux(input logic [7:0] a,
		input logic busy, input logic [1:0] pg, input logic [5:0] pgs,
		input logic [3:0] cf, input logic [3:0] cs, input logic [6:0] rf,
		input logic [6:0] en, input logic es);
		case (a)
			global_regs_pkg::OFF_RESTART_IDENT: rd_mux = {busy, CHIP_IDENT};
			global_regs_pkg::OFF_BANK_SELECT: rd_mux = {pgs, pg};
			global_regs_pkg::OFF_CONV_FAULT: rd_mux = {cs, cf};
			global_regs_pkg::OFF_REG_FAULT: rd_mux = {1'b0, rf};
			global_regs_pkg::OFF_REG_ENABLES: rd_mux = {es, en};
			default: rd_mux = 8'h00;
		endcase
	endfunction : rd_mux

	logic [7:0] ser_rdata_ff;
	logic [7:0] nxt_ser_rdata;
	logic ser_ack_ff;
	logic nxt_ser_ack;
	logic [7:0] uc_rdata_ff;
	logic [7:0] nxt_uc_rdata;
	logic uc_ack_ff;
	logic nxt_uc_ack;
	logic pass_ff;
	logic nxt_pass;
	logic [1:0] pass_page_ff;
	logic [1:0] nxt_pass_page;
	logic [7:0] pass_addr_ff;
	logic [7:0] nxt_pass_addr;
	logic pass_wr_ff;
	logic nxt_pass_wr;
	logic [7:0] pass_wdata_ff;
	logic [7:0] nxt_pass_wdata;
	logic rf_irq_ff;
	logic nxt_rf_irq;
	logic cf_irq_ff;
	logic nxt_cf_irq;
	logic restart_ff;
	logic nxt_restart;
	always_comb begin
		// Paged offsets are acked by the page owner, not by this bank
		nxt_ser_ack = (ser_wr || ser_rd) && ser_glob;
		nxt_ser_rdata = ser_rdata_ff;
		if (ser_rd && ser_glob) begin
			nxt_ser_rdata = rd_mux(ser_addr, restart_busy, page_ff,
				page_spare_ff, conv_s2_ff, conv_spare_ff, regf_s2_ff,
				en_ff, en_spare_ff);
		end
		// Anything outside the global window reads zero on the uc side
		nxt_uc_ack = uc_go;
		nxt_uc_rdata = uc_rdata_ff;
		if (uc_go && uc_rd) begin
			nxt_uc_rdata = uc_hit ? rd_mux(uc_off, restart_busy, page_ff,
				page_spare_ff, conv_s2_ff, conv_spare_ff, regf_s2_ff,
				en_ff, en_spare_ff) : 8'h00;
		end
		// Upper offsets go to the page chosen by the selector
		nxt_pass = (ser_wr || ser_rd) && !ser_glob;
		nxt_pass_page = page_ff;
		nxt_pass_addr = ser_addr;
		nxt_pass_wr = ser_wr;
		nxt_pass_wdata = ser_wdata;
		nxt_rf_irq = |regf_s2_ff;
		nxt_cf_irq = |conv_s2_ff;
		nxt_restart = restart_busy;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			page_ff <= global_regs_pkg::BANK_SELECT_RESET;
			page_spare_ff <= global_regs_pkg::BANK_SPARE_RESET;
			conv_spare_ff <= global_regs_pkg::CONV_SPARE_RESET;
			en_ff <= global_regs_pkg::REG_EN_RESET;
			en_spare_ff <= 1'b0;
			ser_rdata_ff <= 8'h00;
			ser_ack_ff <= 1'b0;
			uc_rdata_ff <= 8'h00;
			uc_ack_ff <= 1'b0;
			pass_ff <= 1'b0;
			pass_page_ff <= 2'h0;
			pass_addr_ff <= 8'h00;
			pass_wr_ff <= 1'b0;
			pass_wdata_ff <= 8'h00;
			rf_irq_ff <= 1'b0;
			cf_irq_ff <= 1'b0;
			restart_ff <= 1'b0;
		end else begin
			page_ff <= nxt_page;
			page_spare_ff <= nxt_page_spare;
			conv_spare_ff <= nxt_conv_spare;
			en_ff <= nxt_en;
			en_spare_ff <= nxt_en_spare;
			ser_rdata_ff <= nxt_ser_rdata;
			ser_ack_ff <= nxt_ser_ack;
			uc_rdata_ff <= nxt_uc_rdata;
			uc_ack_ff <= nxt_uc_ack;
			pass_ff <= nxt_pass;
			pass_page_ff <= nxt_pass_page;
			pass_addr_ff <= nxt_pass_addr;
			pass_wr_ff <= nxt_pass_wr;
			pass_wdata_ff <= nxt_pass_wdata;
			rf_irq_ff <= nxt_rf_irq;
			cf_irq_ff <= nxt_cf_irq;
			restart_ff <= nxt_restart;
		end
	end

	// Bit reads one only while the pulse runs, then clears itself
	restart_pulse #(
		.HOLD(HOLD)
	) u_restart (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.req(restart_req),
		.pulse(restart_busy)
	);

	// Every output comes straight from a flop
	assign ser_rdata = ser_rdata_ff;
	assign ser_ack = ser_ack_ff;
	assign ser_pass = pass_ff;
	assign ser_pass_page = pass_page_ff;
	assign ser_pass_addr = pass_addr_ff;
	assign ser_pass_wr = pass_wr_ff;
	assign ser_pass_wdata = pass_wdata_ff;
	assign uc_rdata = uc_rdata_ff;
	assign uc_ack = uc_ack_ff;
	assign regulator_enables = en_ff;
	assign regulator_fault_irq = rf_irq_ff;
	assign converter_fault_irq = cf_irq_ff;
	// System reset level toward the power sequencer
	assign system_restart = restart_ff;
endmodule : global_register_bank
`default_nettype wire

// [core/global_regs_pkg.sv]
// Purpose: Shared constants for the global register bank
// Assumes: Byte-wide registers, 8-bit page offsets, 2-bit page selector
// Notes: Identity value is arbitrary
package global_regs_pkg;
	localparam int ALIAS_SPAN = 16;
	localparam logic [7:0] OFF_RESTART_IDENT = 8'h00;
	localparam logic [7:0] OFF_BANK_SELECT = 8'h01;
	localparam logic [7:0] OFF_CONV_FAULT = 8'h02;
	localparam logic [7:0] OFF_REG_FAULT = 8'h03;
	localparam logic [7:0] OFF_REG_ENABLES = 8'h04;
	localparam logic [15:0] UC_GLOBAL_BASE = 16'hA000;
	localparam int RESTART_BIT = 7;
	localparam int PAGE_W = 2;
	localparam int CONV_FAULT_W = 4;
	localparam int REG_FAULT_W = 7;
	localparam int REG_EN_W = 7;
	// Arbitrary identity value, not tied to any real part
	localparam logic [6:0] CHIP_IDENT_DEFAULT = 7'h12;
	localparam logic [1:0] BANK_SELECT_RESET = 2'h0;
	localparam logic [5:0] BANK_SPARE_RESET = 6'h00;
	localparam logic [3:0] CONV_SPARE_RESET = 4'h0;
	localparam logic [6:0] REG_EN_RESET = 7'h00;
	localparam int RESTART_HOLD_CYCLES = 4;
endpackage : global_regs_pkg

// [core/restart_pulse.sv]
// Purpose: Stretches the master restart request into a fixed pulse
// Assumes: Request is a one-cycle strobe on core_clk
// Notes: Busy flag lets the bank clear its restart bit when done
`timescale 1ns/1ps
`default_nettype none
module restart_pulse #(
	parameter int HOLD = global_regs_pkg::RESTART_HOLD_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic req,
	output logic pulse
);
	if (HOLD < 1 || HOLD > 255) begin : g_bad_hold
		$error("restart_pulse: HOLD out of range");
	end
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic pulse_ff;
	logic nxt_pulse;
	always_comb begin
		nxt_cnt = cnt_ff;
		if (req && cnt_ff == 8'h00) begin
			nxt_cnt = 8'(HOLD);
		end else if (cnt_ff != 8'h00) begin
			nxt_cnt = cnt_ff - 8'h01;
		end
		nxt_pulse = (nxt_cnt != 8'h00);
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 8'h00;
			pulse_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			pulse_ff <= nxt_pulse;
		end
	end
	assign pulse = pulse_ff;
endmodule : restart_pulse
`default_nettype wire

// [testbench/global_bank_assertions.sv]
// Purpose: Port-level checks for the global register bank
// Assumes: HOLD matches the instance it is bound to
// Notes: Fault latency is two sync stages plus one register
`timescale 1ns/1ps
`default_nettype none
module gbank_chk #(
	parameter int HOLD = 4
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ser_wr,
	input wire logic ser_rd,
	input wire logic [7:0] ser_addr,
	input wire logic [7:0] ser_wdata,
	input wire logic ser_ack,
	input wire logic ser_pass,
	input wire logic uc_wr,
	input wire logic uc_rd,
	input wire logic uc_ack,
	input wire logic [3:0] conv_fault_in,
	input wire logic [6:0] reg_fault_in,
	input wire logic regulator_fault_irq,
	input wire logic converter_fault_irq,
	input wire logic system_restart
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	logic [7:0] hi_ff;
	// Counts restart-high cycles so the pulse length is checked exactly
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_ff <= 8'h00;
		end else begin
			hi_ff <= system_restart ? hi_ff + 8'h01 : 8'h00;
		end
	end
	a_alias_ack: assert property ((ser_wr || ser_rd) && ser_addr < 8'h10
		|=> ser_ack && !ser_pass) else $error("global strobe not acked");
	a_page_pass: assert property ((ser_wr || ser_rd) && ser_addr >= 8'h10
		|=> ser_pass && !ser_ack) else $error("paged strobe not passed");
	a_uc_grant: assert property ((uc_wr || uc_rd) && !ser_wr && !ser_rd
		|=> uc_ack) else $error("uc strobe not acked");
	a_uc_refused: assert property ((uc_wr || uc_rd) && (ser_wr || ser_rd)
		|=> !uc_ack) else $error("refused uc strobe acked");
	a_restart_go: assert property (ser_wr && ser_addr == 8'h00
		&& ser_wdata[7] |=> ##1 system_restart) else $error("no restart");
	a_restart_len: assert property ($fell(system_restart)
		|-> hi_ff == 8'(HOLD)) else $error("restart pulse length wrong");
	a_restart_ends: assert property ($rose(system_restart)
		|-> ##[1:8] !system_restart) else $error("restart stuck high");
	a_conv_irq: assert property ($past(rst_b, 3) && $past(rst_b, 2)
		&& $past(rst_b) |->
		converter_fault_irq == (|$past(conv_fault_in, 3)))
		else $error("converter irq wrong");
	a_reg_irq: assert property ($past(rst_b, 3) && $past(rst_b, 2)
		&& $past(rst_b) |->
		regulator_fault_irq == (|$past(reg_fault_in, 3)))
		else $error("regulator irq wrong");
endmodule : gbank_chk
`default_nettype wire

// [testbench/fault_src.sv]
// Purpose: Far-side fault sources feeding the bank
// Assumes: Faults are plain levels from the supplies
// Notes: Delay keeps edges clear of the sampling clock edge
`timescale 1ns/1ps
`default_nettype none
module fault_src (
	input wire logic [10:0] want,
	output wire logic [3:0] conv,
	output wire logic [6:0] regs
);
	assign #3 {regs, conv} = want;
endmodule : fault_src
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the global register bank
// Assumes: Strobes are one-cycle pulses, acks one cycle later
// Notes: Restart is only written in its own directed case
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk, rst_b, ser_wr, ser_rd, uc_wr, uc_rd, u, w, oor;
	logic [7:0] ser_addr, ser_wdata, uc_wdata, ser_rdata, uc_rdata;
	logic [7:0] ser_pass_addr, ser_pass_wdata, sh1, sh2, sh4, rd, a, d;
	logic [15:0] uc_addr;
	logic [1:0] ser_pass_page;
	logic [3:0] conv_fault_in, cf;
	logic [6:0] reg_fault_in, rf, regulator_enables;
	logic [10:0] want;
	logic ser_ack, ser_pass, ser_pass_wr, uc_ack, system_restart;
	logic regulator_fault_irq, converter_fault_irq;
	logic [31:0] r;
	int n_mismatch, total_checks, seed;
	global_register_bank dut (.core_clk, .rst_b, .ser_wr, .ser_rd, .ser_addr,
		.ser_wdata, .ser_rdata, .ser_ack, .ser_pass, .ser_pass_page,
		.ser_pass_addr, .ser_pass_wr, .ser_pass_wdata, .uc_wr, .uc_rd,
		.uc_addr, .uc_wdata, .uc_rdata, .uc_ack, .conv_fault_in,
		.reg_fault_in, .regulator_enables, .regulator_fault_irq,
		.converter_fault_irq, .system_restart);
	fault_src far (.want, .conv(conv_fault_in), .regs(reg_fault_in));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [7:0] exp_rd(input logic [7:0] off);
		case (off)
			8'h00: return {1'b0, global_regs_pkg::CHIP_IDENT_DEFAULT};
			8'h01: return sh1;
			8'h02: return {sh2[7:4], cf};
			8'h03: return {1'b0, rf};
			8'h04: return sh4;
			default: return 8'h00;
		endcase
	endfunction : exp_rd
	task automatic acc(input logic [7:0] off);
		@(posedge core_clk);
		uc_wr <= u & w;
		uc_rd <= u & !w;
		ser_wr <= !u & w;
		ser_rd <= !u & !w;
		ser_addr <= off;
		ser_wdata <= d;
		uc_wdata <= d;
		uc_addr <= oor ? (off[0] ? 16'hA010 : 16'hB000 + 16'(off))
			: global_regs_pkg::UC_GLOBAL_BASE + 16'(off);
		@(posedge core_clk);
		{ser_wr, ser_rd, uc_wr, uc_rd} <= 4'h0;
		#1;
		rd = u ? uc_rdata : ser_rdata;
		chk("ack", 8'({ser_ack, ser_pass, uc_ack}),
			8'({!u && off < 8'h10, !u && off >= 8'h10, u}));
	endtask : acc
	task automatic final_report;
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
	initial begin
		{ser_wr, ser_rd, uc_wr, uc_rd, rst_b, u, w, oor} = '0;
		{ser_addr, ser_wdata, uc_wdata, uc_addr, d} = '0;
		{sh1, sh2, sh4, want, cf, rf} = '0;
		n_mismatch = 0;
		total_checks = 0;
		seed = 32'haf63;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			acc(8'(i));
			chk("reset", rd, exp_rd(8'(i)));
		end
		repeat (200) begin
			r = $random(seed);
			if (r[31:28] == 4'h0) begin
				want <= r[10:0];
				{rf, cf} = r[10:0];
				repeat (5) @(posedge core_clk);
				#1;
				chk("irq", 8'({regulator_fault_irq, converter_fault_irq}),
					8'({|rf, |cf}));
			end
			u = r[0];
			w = r[1];
			oor = r[0] & r[2] & r[3];
			a = u ? {4'h0, r[7:4]} : {3'h0, r[8:4]};
			d = r[23:16];
			d[7] = d[7] & (a != 8'h00);
			acc(a);
			if (!u && a >= 8'h10) begin
				chk("page", 8'({ser_pass_page, ser_pass_wr}), 8'({sh1[1:0], w}));
				chk("paddr", ser_pass_addr, a);
				chk("pdata", ser_pass_wdata, d);
			end else if (oor) begin
				chk("outside", w ? 8'(regulator_enables) : rd,
					w ? 8'(sh4[6:0]) : 8'h00);
			end else if (w) begin
				sh1 = (a == 8'h01) ? d : sh1;
				sh2 = (a == 8'h02) ? d : sh2;
				sh4 = (a == 8'h04) ? d : sh4;
				chk("enables", 8'(regulator_enables), 8'(sh4[6:0]));
			end else begin
				chk("read", rd, exp_rd(a));
			end
		end
		@(posedge core_clk);
		{ser_rd, uc_wr} <= 2'h3;
		ser_addr <= 8'h03;
		uc_addr <= global_regs_pkg::UC_GLOBAL_BASE + 16'h0004;
		uc_wdata <= ~sh4;
		@(posedge core_clk);
		{ser_rd, uc_wr} <= 2'h0;
		#1;
		chk("arbiter", 8'({ser_ack, uc_ack}), 8'h02);
		chk("refused", 8'(regulator_enables), 8'(sh4[6:0]));
		chk("arb read", ser_rdata, exp_rd(8'h03));
		{u, w, oor, d} = {3'h2, 8'h80};
		acc(8'h00);
		w = 1'b0;
		acc(8'h00);
		chk("restart", 8'({rd[7], system_restart}), 8'h03);
		repeat (8) @(posedge core_clk);
		acc(8'h00);
		chk("cleared", rd, exp_rd(8'h00));
		chk("restart off", 8'(system_restart), 8'h00);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		{sh1, sh4} = '0;
		#1;
		chk("rerun en", 8'(regulator_enables), 8'h00);
		for (int i = 1; i < 5; i += 3) begin
			acc(8'(i));
			chk("rerun", rd, exp_rd(8'(i)));
		end
		final_report();
	end
endmodule : testbench
bind global_register_bank gbank_chk #(.HOLD(HOLD)) chk (.core_clk, .rst_b,
	.ser_wr, .ser_rd, .ser_addr, .ser_wdata, .ser_ack, .ser_pass, .uc_wr,
	.uc_rd, .uc_ack, .conv_fault_in, .reg_fault_in, .regulator_fault_irq,
	.converter_fault_irq, .system_restart);
`default_nettype wire
